// ==== ov_fault_pkg.sv ====
// Constants and types shared by the output over-voltage fault response block
package ov_fault_pkg;

	// ****************************************
	// Command codes of the register map
	// ****************************************
	localparam logic [7:0] CMD_CURRENT_READING_OFFSET = 8'h39;
	localparam logic [7:0] CMD_OV_FAULT_THRESHOLD     = 8'h40;
	localparam logic [7:0] CMD_OV_RESPONSE_POLICY     = 8'h41;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] OFFSET_RESET    = 16'h0000;
	localparam logic [15:0] THRESHOLD_RESET = 16'hFFFF;
	localparam logic [7:0]  POLICY_RESET    = 8'h80;

	// ****************************************
	// Field layout of the response policy byte
	// ****************************************
	localparam int RESP_HI  = 7;
	localparam int RESP_LO  = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;

	// Linear format: low 11 bits hold the mantissa
	localparam int MANT_HI = 10;

	localparam logic [1:0] RESP_IGNORE   = 2'h0;
	localparam logic [1:0] RESP_DELAYED  = 2'h1;
	localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
	localparam logic [1:0] RESP_RESUME   = 2'h3;

	localparam logic [2:0] RETRY_NONE       = 3'h0;
	localparam logic [2:0] RETRY_CONTINUOUS = 3'h7;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ       = 25;
	localparam int DELAY_UNIT_US = 1000;
	localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_US * CLK_MHZ;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_HOLD,
		ST_OFF,
		ST_LATCH,
		ST_RESUME
	} fault_state_t;

endpackage

// ==== ov_fault_response.sv ====
// Output over-voltage fault detection, response policy and register access
module ov_fault_response
	import ov_fault_pkg::*;
#(
	parameter int UNIT_CYCLES = DELAY_UNIT_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_write,
	input  wire logic [15:0] cmd_wdata,
	output logic      [15:0] cmd_rdata,
	input  wire logic [15:0] vout_meas,
	input  wire logic [15:0] iout_raw,
	input  wire logic        on_cmd,
	input  wire logic        clear_fault,
	output logic      [15:0] iout_reported,
	output logic             output_enable,
	output logic             ov_fault,
	output logic             latched_off
);

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0]  offset_reg;
	logic [15:0]  threshold_reg;
	logic [7:0]   policy_reg;
	fault_state_t state_reg;
	fault_state_t state_next;
	logic [31:0]  cnt_reg;
	logic [2:0]   attempts_reg;
	logic [15:0]  rdata_reg;
	logic [15:0]  iout_reg;
	logic         out_en_reg;
	logic         fault_reg;
	logic         latched_reg;

	logic [1:0]   resp;
	logic [2:0]   retry;
	logic [2:0]   delay_sel;
	logic [31:0]  delay_total;
	logic         fault_now;
	logic         expired;
	fault_state_t retry_target;

	assign resp      = policy_reg[RESP_HI:RESP_LO];
	assign retry     = policy_reg[RETRY_HI:RETRY_LO];
	assign delay_sel = policy_reg[DELAY_HI:DELAY_LO];
	assign fault_now = vout_meas > threshold_reg;
	assign expired   = cnt_reg == 32'h0000_0000;

	// Power of two units; UNIT_CYCLES stands in for the separate time-unit register
	assign delay_total = 32'(UNIT_CYCLES) << delay_sel;

	// Continuous retry never counts attempts, so the limit test is skipped
	always_comb begin
		if (retry == RETRY_NONE) begin
			retry_target = ST_LATCH;
		end else if (retry == RETRY_CONTINUOUS || attempts_reg < retry) begin
			retry_target = ST_OFF;
		end else begin
			retry_target = ST_LATCH;
		end
	end

	// ****************************************
	// Register access
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			offset_reg    <= OFFSET_RESET;
			threshold_reg <= THRESHOLD_RESET;
			policy_reg    <= POLICY_RESET;
		end else if (cmd_write) begin
			if (cmd_code == CMD_CURRENT_READING_OFFSET) begin
				offset_reg <= cmd_wdata;
			end
			if (cmd_code == CMD_OV_FAULT_THRESHOLD) begin
				threshold_reg <= cmd_wdata;
			end
			if (cmd_code == CMD_OV_RESPONSE_POLICY) begin
				policy_reg <= cmd_wdata[7:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdata_reg <= 16'h0000;
		end else begin
			unique case (cmd_code)
				CMD_CURRENT_READING_OFFSET: rdata_reg <= offset_reg;
				CMD_OV_FAULT_THRESHOLD:     rdata_reg <= threshold_reg;
				CMD_OV_RESPONSE_POLICY:     rdata_reg <= {8'h00, policy_reg};
				default:                    rdata_reg <= 16'h0000;
			endcase
		end
	end

	// ****************************************
	// Current reading offset
	// ****************************************
	// Mantissas add at the reading's exponent; offset exponent must match the reading's
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			iout_reg <= 16'h0000;
		end else begin
			iout_reg <= {iout_raw[15:MANT_HI+1], iout_raw[MANT_HI:0] + offset_reg[MANT_HI:0]};
		end
	end

	// ****************************************
	// Fault response sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (fault_now) begin
					unique case (resp)
						RESP_IGNORE:   state_next = ST_RUN;
						RESP_DELAYED:  state_next = ST_HOLD;
						RESP_SHUTDOWN: state_next = retry_target;
						RESP_RESUME:   state_next = ST_RESUME;
					endcase
				end
			end
			ST_HOLD: begin
				if (expired) begin
					state_next = fault_now ? retry_target : ST_RUN;
				end
			end
			ST_OFF: begin
				if (expired) begin
					state_next = ST_RUN;
				end
			end
			ST_LATCH: begin
				if (clear_fault) begin
					state_next = ST_RUN;
				end
			end
			ST_RESUME: begin
				if (!fault_now) begin
					state_next = ST_RUN;
				end
			end
		endcase
		// Commanded off ends any sequence, including continuous retry
		if (!on_cmd) begin
			state_next = ST_RUN;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Delay counter loads on entry to a timed state
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_reg <= 32'h0000_0000;
		end else if (state_next != state_reg &&
				(state_next == ST_HOLD || state_next == ST_OFF)) begin
			cnt_reg <= delay_total - 32'h0000_0001;
		end else if (!expired) begin
			cnt_reg <= cnt_reg - 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			attempts_reg <= 3'h0;
		end else if (!on_cmd || clear_fault) begin
			attempts_reg <= 3'h0;
		end else if (state_reg == ST_OFF && expired && retry != RETRY_CONTINUOUS) begin
			attempts_reg <= attempts_reg + 3'h1;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			out_en_reg  <= 1'b0;
			fault_reg   <= 1'b0;
			latched_reg <= 1'b0;
		end else begin
			out_en_reg  <= on_cmd && (state_next == ST_RUN || state_next == ST_HOLD);
			fault_reg   <= fault_now;
			latched_reg <= state_next == ST_LATCH;
		end
	end

	assign cmd_rdata     = rdata_reg;
	assign iout_reported = iout_reg;
	assign output_enable = out_en_reg;
	assign ov_fault      = fault_reg;
	assign latched_off   = latched_reg;

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_enter_off;
		state_reg != ST_OFF ##1 state_reg == ST_OFF;
	endsequence
	sequence s_shutdown_fault;
		state_reg == ST_RUN && resp == RESP_SHUTDOWN && fault_now && on_cmd;
	endsequence

	property p_iout_offset;
		@(posedge clk_sys) disable iff (!reset_n)
		1 |=> iout_reported[MANT_HI:0] ==
			$past(iout_raw[MANT_HI:0]) + $past(offset_reg[MANT_HI:0]);
	endproperty
	a_iout_offset: assert property (p_iout_offset) else $error("Offset not applied");
	property p_threshold_write;
		@(posedge clk_sys) disable iff (!reset_n)
		cmd_write && cmd_code == CMD_OV_FAULT_THRESHOLD ##1 cmd_code == CMD_OV_FAULT_THRESHOLD
			|=> cmd_rdata == $past(cmd_wdata, 2);
	endproperty
	a_threshold_write: assert property (p_threshold_write) else $error("Threshold readback");
	property p_ignore;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == ST_RUN && resp == RESP_IGNORE && on_cmd |=> output_enable;
	endproperty
	a_ignore: assert property (p_ignore) else $error("Ignore mode dropped output");
	property p_hold_running;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == ST_HOLD && on_cmd && !expired |=> output_enable;
	endproperty
	a_hold_running: assert property (p_hold_running) else $error("Output off during delay");
	property p_shutdown;
		@(posedge clk_sys) disable iff (!reset_n)
		s_shutdown_fault |=> !output_enable && state_reg != ST_RUN;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("Shutdown not immediate");
	property p_resume;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == ST_RESUME && fault_now && on_cmd |=> !output_enable;
	endproperty
	a_resume_off: assert property (p_resume) else $error("Output on during fault");
	property p_resume_on;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == ST_RESUME && !fault_now && on_cmd |=> output_enable;
	endproperty
	a_resume_on: assert property (p_resume_on) else $error("Output not resumed");
	property p_no_retry;
		@(posedge clk_sys) disable iff (!reset_n)
		(s_shutdown_fault and retry == RETRY_NONE) ##1 (!clear_fault && on_cmd)
			|=> latched_off;
	endproperty
	a_no_retry: assert property (p_no_retry) else $error("Restart without retries");
	property p_retry_delay;
		@(posedge clk_sys) disable iff (!reset_n)
		s_enter_off |-> cnt_reg == $past(delay_total) - 32'h0000_0001;
	endproperty
	a_retry_delay: assert property (p_retry_delay) else $error("Retry delay wrong");
	// Checked at the decision itself, where a wrong limit test would latch
	property p_continuous;
		@(posedge clk_sys) disable iff (!reset_n)
		(s_shutdown_fault and retry == RETRY_CONTINUOUS) |=> state_reg == ST_OFF;
	endproperty
	a_continuous: assert property (p_continuous) else $error("Continuous retry latched");
	property p_fault_flag;
		@(posedge clk_sys) disable iff (!reset_n)
		1 |=> ov_fault == ($past(vout_meas) > $past(threshold_reg));
	endproperty
	a_fault_flag: assert property (p_fault_flag) else $error("Fault flag wrong");
	property p_attempt_limit;
		@(posedge clk_sys) disable iff (!reset_n)
		state_reg == ST_OFF && expired && retry != RETRY_CONTINUOUS && on_cmd && !clear_fault
			|=> attempts_reg <= retry;
	endproperty
	a_attempt_limit: assert property (p_attempt_limit) else $error("Too many restarts");

endmodule

// ==== ov_host_model.sv ====
// Management bus host model driving the command port
module ov_host_model
	import ov_fault_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic [15:0] cmd_rdata,
	output logic      [7:0]  cmd_code,
	output logic             cmd_write,
	output logic      [15:0] cmd_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cmd_code = 8'h00;
		cmd_write = 1'b0;
		cmd_wdata = 16'h0000;
	end

	// Released data is scrambled so a stale word never looks valid
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		@(negedge clk_sys);
		cmd_code = code;
		cmd_wdata = data;
		cmd_write = 1'b1;
		@(negedge clk_sys);
		cmd_write = 1'b0;
		cmd_wdata = ~data;
	endtask

	task automatic rd(input logic [7:0] code, output logic [15:0] data);
		@(negedge clk_sys);
		cmd_code = code;
		repeat (2) @(negedge clk_sys);
		data = cmd_rdata;
	endtask
endmodule

// ==== tb_top.sv ====
// Self-checking testbench of the over-voltage fault response block
module tb_top;
	import ov_fault_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int UNIT = 4;
	logic clk_sys, reset_n, cmd_write, on_cmd, clear_fault;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, vout_meas, iout_raw, iout_reported, rv;
	logic output_enable, ov_fault, latched_off;
	int error_cnt = 0;
	int num_checks = 0;

	ov_fault_response #(.UNIT_CYCLES(UNIT)) ov_fault_response_i (.clk_sys(clk_sys),
		.reset_n(reset_n), .cmd_code(cmd_code), .cmd_write(cmd_write),
		.cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .vout_meas(vout_meas),
		.iout_raw(iout_raw), .on_cmd(on_cmd), .clear_fault(clear_fault),
		.iout_reported(iout_reported), .output_enable(output_enable),
		.ov_fault(ov_fault), .latched_off(latched_off));
	ov_host_model ov_host_model_i (.clk_sys(clk_sys), .cmd_rdata(cmd_rdata),
		.cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic fault(input logic on);
		@(negedge clk_sys);
		vout_meas = on ? 16'h2000 : 16'h0800;
	endtask

	// Fault removed and cleared so each scenario starts from normal running
	task automatic clr();
		fault(1'b0);
		clear_fault = 1'b1;
		cyc(1);
		clear_fault = 1'b0;
		cyc(3);
	endtask

	task automatic pol(input logic [7:0] p);
		ov_host_model_i.wr(CMD_OV_RESPONSE_POLICY, {8'h00, p});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		ov_host_model_i.rd(CMD_OV_FAULT_THRESHOLD, rv);
		chk_word(rv, THRESHOLD_RESET);
		ov_host_model_i.rd(CMD_OV_RESPONSE_POLICY, rv);
		chk_word(rv, {8'h00, POLICY_RESET});
		ov_host_model_i.rd(8'h42, rv);
		chk_word(rv, 16'h0000);
		chk_word(iout_reported, 16'h1803);
		ov_host_model_i.wr(CMD_CURRENT_READING_OFFSET, 16'hFFFF);
		ov_host_model_i.wr(CMD_OV_FAULT_THRESHOLD, 16'h1000);
		cyc(2);
		chk_word(iout_reported, 16'h1802);
		ov_host_model_i.rd(CMD_CURRENT_READING_OFFSET, rv);
		chk_word(rv, 16'hFFFF);
		ov_host_model_i.rd(CMD_OV_FAULT_THRESHOLD, rv);
		chk_word(rv, 16'h1000);
	endtask

	task automatic t_modes();
		pol(8'h00);
		fault(1'b1);
		cyc(20);
		chk_bit(ov_fault, 1'b1);
		chk_bit(output_enable, 1'b1);
		clr();
		pol(8'hC0);
		fault(1'b1);
		cyc(4);
		chk_bit(output_enable, 1'b0);
		fault(1'b0);
		cyc(3);
		chk_bit(output_enable, 1'b1);
		chk_bit(latched_off, 1'b0);
		pol(8'h41);
		fault(1'b1);
		cyc(4);
		chk_bit(output_enable, 1'b1);
		cyc(12);
		chk_bit(latched_off, 1'b1);
		clr();
		pol(8'h43);
		fault(1'b1);
		cyc(4);
		fault(1'b0);
		cyc(40);
		chk_bit(output_enable, 1'b1);
	endtask

	task automatic t_retries();
		int n;
		logic prev;
		pol(8'h80);
		fault(1'b1);
		cyc(6);
		fault(1'b0);
		cyc(10);
		chk_bit(output_enable, 1'b0);
		clr();
		for (int r = 1; r <= 6; r++) begin
			pol({2'h2, r[2:0], 3'h0});
			fault(1'b1);
			n = 0;
			prev = 1'b1;
			for (int i = 0; i < 200 && latched_off !== 1'b1; i++) begin
				cyc(1);
				if (output_enable === 1'b1 && !prev) n++;
				prev = output_enable;
			end
			chk_word(n[15:0], r[15:0]);
			clr();
		end
		pol(8'h8A);
		fault(1'b1);
		for (int i = 0; i < 20 && output_enable !== 1'b0; i++) cyc(1);
		n = 0;
		while (output_enable === 1'b0 && n < 300) begin
			cyc(1);
			n++;
		end
		chk_word(n[15:0], 16'(UNIT << 2));
		clr();
		pol(8'hB8);
		fault(1'b1);
		cyc(80);
		chk_bit(latched_off, 1'b0);
		on_cmd = 1'b0;
		cyc(3);
		chk_bit(output_enable, 1'b0);
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		reset_n = 1'b0;
		on_cmd = 1'b1;
		clear_fault = 1'b0;
		vout_meas = 16'h0800;
		iout_raw = 16'h1803;
		cyc(10);
		reset_n = 1'b1;
		cyc(1);
		t_regs();
		t_modes();
		t_retries();
		tally_and_finish();
	end

	// Far beyond the few hundred cycles the scenarios need
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		tally_and_finish();
	end
endmodule
